// File: irc_bank.v
// Interrupt routing and data receiver control register bank.
//
// Operation
// RL1: A route bit at zero sends its event to pin A; all route bits reset zero.
// RL2: Low route bits 2,1,0 steer PLL locked, over threshold, output muted.
// RL3: High route register at 0x08, reset 0x00, bits 7,6,5,4,2,1,0 as listed.
// RL4: Aux pin function field: 0 none, 1 parity, 2 frame, 3 reserved.
// RL5: Host sets parity_in_use bit 5 whenever parity is used.
// RL6: Host sets frame_in_use bit 4 whenever the frame signal is used.
// RL7: Frame config register at 0x09 resets to 0x00.
// RL8: Lock control at 0x0A resets 0x40; bit 7 enables the lock loop.
// RL9: Bit 6 enables duty-cycle correction, reset one.
// RL10: Phase offset field sets locked phase 90 plus n times 11.25 degrees.
// RL11: Host keeps sign-magnitude phase offset within minus six to plus six.
// RL12: Writing one to warn control bit 7 clears status 0x0E bits 6 to 4.
// RL13: Host keeps warn control bits 6 to 0 at 0x39.
// RL14: Tuning control register at 0x0C resets to 0x64.
// RL15: Status bit 6 near end, bit 5 at start, bit 4 at end; read only.
// RL16: Each interrupt pin is the OR of the events routed to it.
// RL17: The clear-warning control is a self-clearing pulse.
`timescale 1ns/1ns
`include "irc_map.vh"
module irc_bank (
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Register port from the serial control port
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Event flags: {parity, sample_error_detect, loop warn, loop locked, rsvd, fifo under, fifo over, fifo warn}
  input wire [7:0] event_hi_i,
  // Event flags for the low route register, bit order as the register
  input wire [7:0] event_lo_i,
  // Lock loop status sources
  input wire loop_locked_i,
  input wire [2:0] warn_set_i,
  input wire clock_present_i,
  input wire loop_running_i,
  // Interrupt pins
  output reg interrupt_pin_a_o,
  output reg interrupt_pin_b_o,
  // Receiver controls
  output reg loop_enable_o,
  output reg duty_correct_o,
  output reg [3:0] phase_offset_o,
  output reg parity_in_use_o,
  output reg frame_in_use_o,
  output reg aux_parity_o,
  output reg aux_frame_o,
  output reg [7:0] tuning_o,
  output reg warn_clear_o
);
  // Register copies of the bank; the clear-warning bit is never stored.
  reg [7:0] route_lo_r;
  reg [7:0] route_hi_r;
  reg [7:0] frame_cfg_r;
  reg [7:0] lock_ctrl_r;
  reg [7:0] warn_ctrl_r;
  reg [7:0] tune_ctrl_r;
  reg clr_pulse_r;

  // Next values of the bank registers.
  reg [7:0] route_lo_nxt;
  reg [7:0] route_hi_nxt;
  reg [7:0] frame_cfg_nxt;
  reg [7:0] lock_ctrl_nxt;
  reg [7:0] warn_ctrl_nxt;
  reg [7:0] tune_ctrl_nxt;
  reg clr_pulse_nxt;

  // Next values of the registered outputs.
  reg pin_a_nxt;
  reg pin_b_nxt;
  reg loop_enable_nxt;
  reg duty_correct_nxt;
  reg [3:0] phase_offset_nxt;
  reg parity_in_use_nxt;
  reg frame_in_use_nxt;
  reg aux_parity_nxt;
  reg aux_frame_nxt;
  reg [7:0] tuning_nxt;
  reg warn_clear_nxt;
  reg [7:0] rdata_nxt;

  // Write selects, status word and router nets.
  wire sel_lo_w;
  wire sel_hi_w;
  wire sel_frame_w;
  wire sel_lock_w;
  wire sel_warn_w;
  wire sel_tune_w;
  wire [2:0] warn_w;
  wire pin_a_w;
  wire pin_b_w;
  wire [7:0] status_w;
  wire [7:0] hi_mask_w;
  wire [7:0] event_hi_w;
  genvar g;

  // Write select for one offset.
  function hit;
    input [6:0] a;
    input [6:0] off;
    begin
      hit = reg_wr_i && (a == off);
    end
  endfunction

  // RL4: aux pin decode.
  // Reserved code 3 drives neither function, so a stray write cannot enable both.
  function [1:0] aux_dec;
    input [1:0] mode;
    begin
      case (mode)
        `IRC_AUX_PARITY: aux_dec = 2'b01;
        `IRC_AUX_FRAME: aux_dec = 2'b10;
        default: aux_dec = 2'b00;
      endcase
    end
  endfunction

  // One strobe reaches at most one register; writes to status or unmapped offsets are dropped.
  assign sel_lo_w = hit(reg_addr_i, `IRC_OFF_ROUTE_LO);
  assign sel_hi_w = hit(reg_addr_i, `IRC_OFF_ROUTE_HI);
  assign sel_frame_w = hit(reg_addr_i, `IRC_OFF_FRAME_CFG);
  assign sel_lock_w = hit(reg_addr_i, `IRC_OFF_LOCK_CTRL);
  assign sel_warn_w = hit(reg_addr_i, `IRC_OFF_WARN_CTRL);
  assign sel_tune_w = hit(reg_addr_i, `IRC_OFF_TUNE_CTRL);

  always @* begin
    route_lo_nxt = route_lo_r;
    route_hi_nxt = route_hi_r;
    frame_cfg_nxt = frame_cfg_r;
    lock_ctrl_nxt = lock_ctrl_r;
    warn_ctrl_nxt = warn_ctrl_r;
    tune_ctrl_nxt = tune_ctrl_r;
    clr_pulse_nxt = 1'b0;

    // RL2: low route write.
    if (sel_lo_w) begin
      route_lo_nxt = reg_wdata_i;
    end
    // Unimplemented bits are masked so that they always read back zero.
    // RL3: high route write.
    if (sel_hi_w) begin
      route_hi_nxt = reg_wdata_i & `IRC_MASK_ROUTE_HI;
    end
    // RL7: frame config write.
    if (sel_frame_w) begin
      frame_cfg_nxt = reg_wdata_i & `IRC_MASK_FRAME_CFG;
    end
    // RL8: lock control write.
    if (sel_lock_w) begin
      lock_ctrl_nxt = reg_wdata_i & `IRC_MASK_LOCK_CTRL;
    end
    // RL17: self-clearing clear bit.
    // The bit is not stored, so the host never has to write it back to zero.
    if (sel_warn_w) begin
      warn_ctrl_nxt = {1'b0, reg_wdata_i[6:0]};
      clr_pulse_nxt = reg_wdata_i[`IRC_BIT_CLR_WARN];
    end
    // RL14: tuning write.
    if (sel_tune_w) begin
      tune_ctrl_nxt = reg_wdata_i;
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // RL1: routes reset zero.
      route_lo_r <= `IRC_RST_ROUTE_LO;
      route_hi_r <= `IRC_RST_ROUTE_HI;
      // RL7: frame config reset.
      frame_cfg_r <= `IRC_RST_FRAME_CFG;
      // RL8: lock control reset.
      lock_ctrl_r <= `IRC_RST_LOCK_CTRL;
      warn_ctrl_r <= `IRC_RST_WARN_CTRL;
      // RL14: tuning reset value.
      tune_ctrl_r <= `IRC_RST_TUNE_CTRL;
      clr_pulse_r <= 1'b0;
    end else begin
      route_lo_r <= route_lo_nxt;
      route_hi_r <= route_hi_nxt;
      frame_cfg_r <= frame_cfg_nxt;
      lock_ctrl_r <= lock_ctrl_nxt;
      warn_ctrl_r <= warn_ctrl_nxt;
      tune_ctrl_r <= tune_ctrl_nxt;
      clr_pulse_r <= clr_pulse_nxt;
    end
  end

  // RL12: clear strobe to warnings.
  irc_warn u_warn (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .warn_set_i(warn_set_i),
    .clear_i(clr_pulse_r),
    .warn_o(warn_w)
  );

  // RL3: route slot 3 ignored.
  // Bit 3 has no route bit behind it, so its event is dropped rather than sent to pin A.
  assign hi_mask_w = `IRC_MASK_ROUTE_HI;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_evt_hi
      assign event_hi_w[g] = event_hi_i[g] & hi_mask_w[g];
    end
  endgenerate

  // RL1: select zero steers to pin A.
  // RL2: low route events.
  irc_route u_route (
    .event_i({event_hi_w, event_lo_i}),
    .sel_i({route_hi_r, route_lo_r}),
    .pin_a_o(pin_a_w),
    .pin_b_o(pin_b_w)
  );

  // RL15: read-only status.
  // Bits 3 and 1 are reserved and read zero.
  assign status_w = {loop_locked_i, warn_w, 1'b0, clock_present_i, 1'b0, loop_running_i};

  always @* begin
    // RL16: pins from router.
    pin_a_nxt = pin_a_w;
    pin_b_nxt = pin_b_w;
    // RL8: loop enable.
    loop_enable_nxt = lock_ctrl_r[`IRC_BIT_LOOP_EN];
    // RL9: duty correction.
    duty_correct_nxt = lock_ctrl_r[`IRC_BIT_DUTY_EN];
    // RL10: phase offset field.
    phase_offset_nxt = lock_ctrl_r[3:0];
    parity_in_use_nxt = frame_cfg_r[`IRC_BIT_PARITY_USE];
    frame_in_use_nxt = frame_cfg_r[`IRC_BIT_FRAME_USE];
    // RL4: aux pin decode.
    {aux_frame_nxt, aux_parity_nxt} = aux_dec(frame_cfg_r[1:0]);
    tuning_nxt = tune_ctrl_r;
    warn_clear_nxt = clr_pulse_r;
  end

  // Read data holds between reads, so a slow host may sample it late; unmapped offsets read zero.
  always @* begin
    rdata_nxt = reg_rdata_o;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `IRC_OFF_ROUTE_LO: rdata_nxt = route_lo_r;
        `IRC_OFF_ROUTE_HI: rdata_nxt = route_hi_r;
        `IRC_OFF_FRAME_CFG: rdata_nxt = frame_cfg_r;
        `IRC_OFF_LOCK_CTRL: rdata_nxt = lock_ctrl_r;
        `IRC_OFF_WARN_CTRL: rdata_nxt = warn_ctrl_r;
        `IRC_OFF_TUNE_CTRL: rdata_nxt = tune_ctrl_r;
        `IRC_OFF_RX_STATUS: rdata_nxt = status_w;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Outputs registered so pins and controls come straight from flip-flops.
  // The cost is one cycle of delay between a register write and its control output.
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // RL16: pins idle low.
      interrupt_pin_a_o <= 1'b0;
      interrupt_pin_b_o <= 1'b0;
      // RL8: loop disabled.
      loop_enable_o <= 1'b0;
      // RL9: duty correction on.
      duty_correct_o <= 1'b1;
      // RL10: phase offset zero.
      phase_offset_o <= 4'h0;
      parity_in_use_o <= 1'b0;
      frame_in_use_o <= 1'b0;
      // RL4: no aux function.
      aux_parity_o <= 1'b0;
      aux_frame_o <= 1'b0;
      // RL14: tuning reset copy.
      tuning_o <= `IRC_RST_TUNE_CTRL;
      // RL17: no clear pulse.
      warn_clear_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      interrupt_pin_a_o <= pin_a_nxt;
      interrupt_pin_b_o <= pin_b_nxt;
      loop_enable_o <= loop_enable_nxt;
      duty_correct_o <= duty_correct_nxt;
      phase_offset_o <= phase_offset_nxt;
      parity_in_use_o <= parity_in_use_nxt;
      frame_in_use_o <= frame_in_use_nxt;
      aux_parity_o <= aux_parity_nxt;
      aux_frame_o <= aux_frame_nxt;
      tuning_o <= tuning_nxt;
      warn_clear_o <= warn_clear_nxt;
      reg_rdata_o <= rdata_nxt;
    end
  end
endmodule // irc_bank

// File: irc_bank_assertions.sv
// Concurrent checks on the routing and receiver control bank ports.
`timescale 1ns/1ns
module irc_chk (
  // Clock, reset and register port
  input wire core_clk_i,
  input wire resetn_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  // Events and outputs
  input wire [7:0] event_hi_i,
  input wire [7:0] event_lo_i,
  input wire interrupt_pin_a_o,
  input wire loop_enable_o,
  input wire duty_correct_o,
  input wire [3:0] phase_offset_o,
  input wire aux_parity_o,
  input wire [7:0] tuning_o,
  input wire warn_clear_o
);
  reg [7:0] lo_r;
  reg [7:0] hi_r;
  wire wa = reg_wr_i && reg_addr_i == 7'h0a;
  wire wb = reg_wr_i && reg_addr_i == 7'h0b && reg_wdata_i[7];
  wire [7:0] to_a = (event_lo_i & ~lo_r) | (event_hi_i & ~hi_r & 8'hf7);
  // Route copies let the pin be judged from the ports alone.
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lo_r <= 8'h00;
      hi_r <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 7'h07)
        lo_r <= reg_wdata_i;
      if (reg_addr_i == 7'h08)
        hi_r <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_loop_en_copy: assert property (wa |-> ##2 loop_enable_o == $past(reg_wdata_i[7], 2))
    else $error("loop enable wrong");
  a_duty_en_copy: assert property (wa |-> ##2 duty_correct_o == $past(reg_wdata_i[6], 2))
    else $error("duty correction wrong");
  a_phase_copy: assert property (wa |-> ##2 phase_offset_o == $past(reg_wdata_i[3:0], 2))
    else $error("phase offset wrong");
  a_tune_copy: assert property (reg_wr_i && reg_addr_i == 7'h0c |-> ##2 tuning_o == $past(reg_wdata_i, 2))
    else $error("tuning copy wrong");
  a_aux_parity_dec: assert property (reg_wr_i && reg_addr_i == 7'h09 |-> ##2
    aux_parity_o == ($past(reg_wdata_i[1:0], 2) == 2'h1)) else $error("aux decode wrong");
  a_clear_pulse: assert property (wb |-> ##2 warn_clear_o)
    else $error("clear pulse missing");
  a_clear_cause: assert property ($rose(warn_clear_o) |-> $past(wb, 2))
    else $error("clear pulse without write");
  a_clear_single: assert property (warn_clear_o && !$past(wb) |=> !warn_clear_o)
    else $error("clear pulse too long");
  a_pin_a_or: assert property (!$past(reg_wr_i) && $stable(to_a) |-> interrupt_pin_a_o == |to_a)
    else $error("pin a wrong");
endmodule // irc_chk
bind irc_bank irc_chk u_chk (.*);

// File: irc_map.vh
// Register offsets, field positions and reset values of the routing and receiver control bank.
`ifndef IRC_MAP_VH
`define IRC_MAP_VH
`define IRC_ADDR_W 7
`define IRC_OFF_ROUTE_LO 7'h07
`define IRC_OFF_ROUTE_HI 7'h08
`define IRC_OFF_FRAME_CFG 7'h09
`define IRC_OFF_LOCK_CTRL 7'h0a
`define IRC_OFF_WARN_CTRL 7'h0b
`define IRC_OFF_TUNE_CTRL 7'h0c
`define IRC_OFF_RX_STATUS 7'h0e
`define IRC_RST_ROUTE_LO 8'h00
`define IRC_RST_ROUTE_HI 8'h00
`define IRC_RST_FRAME_CFG 8'h00
`define IRC_RST_LOCK_CTRL 8'h40
`define IRC_RST_WARN_CTRL 8'h39
`define IRC_RST_TUNE_CTRL 8'h64
`define IRC_MASK_ROUTE_HI 8'hf7
`define IRC_MASK_FRAME_CFG 8'h33
`define IRC_MASK_LOCK_CTRL 8'hcf
`define IRC_BIT_PARITY_USE 5
`define IRC_BIT_FRAME_USE 4
`define IRC_BIT_LOOP_EN 7
`define IRC_BIT_DUTY_EN 6
`define IRC_BIT_CLR_WARN 7
`define IRC_AUX_NONE 2'h0
`define IRC_AUX_PARITY 2'h1
`define IRC_AUX_FRAME 2'h2
`define IRC_AUX_RSVD 2'h3
`define IRC_RST_STATUS 8'h00
`endif

// File: irc_route.v
// Steers event flags onto the two interrupt pins by a per-flag select word.
`timescale 1ns/1ns
module irc_route (
  // Events and selects
  input wire [15:0] event_i,
  input wire [15:0] sel_i,
  // Pin requests
  output wire pin_a_o,
  output wire pin_b_o
);
  // RL1: select low picks A.
  // RL16: OR per pin.
  assign pin_a_o = |(event_i & ~sel_i);
  assign pin_b_o = |(event_i & sel_i);
endmodule // irc_route

// File: irc_warn.v
// Holds the three receiver warning status bits with a clear strobe.
`timescale 1ns/1ns
module irc_warn (
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Warning sources and clear
  input wire [2:0] warn_set_i,
  input wire clear_i,
  // Status
  output reg [2:0] warn_o
);
  // RL12: warnings cleared on strobe.
  // A warning that is set in the clearing cycle survives, so no event is lost.
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warn_o <= 3'h0;
    end else begin
      warn_o <= (clear_i ? 3'h0 : warn_o) | warn_set_i;
    end
  end
endmodule // irc_warn

// File: tb.sv
// Self-checking bench for the routing and receiver control bank.
`timescale 1ns/1ns
module tb;
  reg core_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg [6:0] reg_addr_i = 7'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg [7:0] event_hi_i = 8'h00;
  reg [7:0] event_lo_i = 8'h00;
  reg loop_locked_i = 1'b0;
  reg [2:0] warn_set_i = 3'h0;
  reg clock_present_i = 1'b0;
  reg loop_running_i = 1'b0;
  wire [7:0] reg_rdata_o;
  wire [7:0] tuning_o;
  wire [3:0] phase_offset_o;
  wire interrupt_pin_a_o, interrupt_pin_b_o, loop_enable_o, duty_correct_o, parity_in_use_o;
  wire frame_in_use_o, aux_parity_o, aux_frame_o, warn_clear_o;
  integer err_total = 0;
  integer n_compared = 0;
  integer i;
  irc_bank dut (.*);
  initial forever #50 core_clk_i = ~core_clk_i;
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
    end
  endtask
  task rd(input [6:0] a, input [7:0] exp);
    begin
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      chk(reg_rdata_o, exp);
    end
  endtask
  task ev(input [7:0] lo, input [7:0] hi, input [1:0] exp);
    begin
      @(posedge core_clk_i);
      event_lo_i <= lo;
      event_hi_i <= hi;
      repeat (2) @(posedge core_clk_i);
      #1;
      chk({interrupt_pin_b_o, interrupt_pin_a_o}, exp);
    end
  endtask
  task t_reset;
    begin
      rd(7'h07, 8'h00);
      rd(7'h08, 8'h00);
      rd(7'h09, 8'h00);
      rd(7'h0a, 8'h40);
      rd(7'h0b, 8'h39);
      rd(7'h0c, 8'h64);
      rd(7'h0e, 8'h00);
      rd(7'h7f, 8'h00);
      chk({loop_enable_o, duty_correct_o}, 8'h01);
    end
  endtask
  task t_masks;
    begin
      wr(7'h08, 8'hff);
      rd(7'h08, 8'hf7);
      wr(7'h0a, 8'hff);
      rd(7'h0a, 8'hcf);
      wr(7'h0e, 8'hff);
      rd(7'h0e, 8'h00);
      wr(7'h0c, 8'ha5);
      chk(tuning_o, 8'ha5);
      wr(7'h0a, 8'h85);
      chk({loop_enable_o, duty_correct_o, 2'h0, phase_offset_o}, 8'h85);
    end
  endtask
  task t_aux;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(7'h09, 8'h30 | i);
        chk({aux_frame_o, aux_parity_o}, (i == 3) ? 0 : i);
        chk({parity_in_use_o, frame_in_use_o}, 8'h03);
      end
      rd(7'h09, 8'h33);
    end
  endtask
  task t_route;
    begin
      wr(7'h07, 8'h00);
      wr(7'h08, 8'h00);
      ev(8'h04, 8'h00, 2'h1);
      wr(7'h07, 8'h04);
      chk({interrupt_pin_b_o, interrupt_pin_a_o}, 8'h02);
      ev(8'h00, 8'h08, 2'h0);
      wr(7'h08, 8'h80);
      ev(8'h00, 8'h81, 2'h3);
      ev(8'h00, 8'h00, 2'h0);
    end
  endtask
  task t_warn;
    begin
      @(posedge core_clk_i);
      warn_set_i <= 3'h7;
      loop_locked_i <= 1'b1;
      clock_present_i <= 1'b1;
      loop_running_i <= 1'b1;
      @(posedge core_clk_i);
      warn_set_i <= 3'h0;
      rd(7'h0e, 8'hf5);
      wr(7'h0b, 8'hb9);
      chk(warn_clear_o, 8'h01);
      rd(7'h0e, 8'h85);
      rd(7'h0b, 8'h39);
      @(posedge core_clk_i);
      warn_set_i <= 3'h2;
      @(posedge core_clk_i);
      warn_set_i <= 3'h0;
      rd(7'h0e, 8'ha5);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d compared %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_reset;
    t_masks;
    t_aux;
    t_route;
    t_warn;
    summarize;
  end
endmodule // tb
